// file: rtl/mie_pkg.sv
// Package for the instruction execute block: opcodes, field layout, widths and reset values.
// Assumes a 14-bit instruction word and an 8-bit data path with a 13-bit program counter.
package mie_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;

  // ----------------------------------------------------------------
  // Register map of the bus slave (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_FILE_IN = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_LATCH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_FILE_OUT = 8'h18;
  localparam logic [7:0] ADDR_STACK = 8'h1C;
  localparam logic [7:0] ADDR_WDOG = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 7;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;
  localparam int ST_Z = 0;
  localparam int ST_POWERDOWN = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_BUSY = 3;
  localparam int FO_VALID = 8;
  localparam int FO_ADDR_LO = 9;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] OP6_CLEAR = 6'h01;
  localparam logic [5:0] OP6_DEC = 6'h03;
  localparam logic [5:0] OP6_IOR = 6'h04;
  localparam logic [5:0] OP6_MOVE = 6'h08;
  localparam logic [5:0] OP6_COM = 6'h09;
  localparam logic [5:0] OP6_INC = 6'h0A;
  localparam logic [5:0] OP6_DECSKIP = 6'h0B;
  localparam logic [5:0] OP6_INCSKIP = 6'h0F;
  localparam logic [5:0] OP6_ORLIT = 6'h38;
  localparam logic [3:0] OP4_LOADLIT = 4'hC;
  localparam logic [2:0] OP3_CALL = 3'h4;
  localparam logic [2:0] OP3_BRANCH = 3'h5;
  localparam logic [13:0] OP_WDOG_CLEAR = 14'h0064;

  // ----------------------------------------------------------------
  // Constants and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] WDOG_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [1:0] {
    MIE_ST_EXEC = 2'b01,
    MIE_ST_NOP = 2'b10
  } mie_state_type;

endpackage

// file: rtl/mie_exec.sv
// Execute stage for a subset of 14-bit instructions, reached over AHB-Lite.
// Assumes a single-master bus with one slave, word transfers only, and software
// standing in for fetch, file register and watchdog by writing and reading words.
//
// Functional notes
// - Move-file copies the file register to the destination and updates the zero flag.
// - Decrement-file subtracts one, writes the destination, updates zero, in one cycle.
// - Increment-file adds one with 0xFF wrapping to 0x00, writes it and updates zero.
// - The skip forms write the result and, when it is zero, run a no-operation second cycle.
// - Call pushes the program counter plus one as the new top of stack.
// - Call loads its 11-bit literal into program counter bits 10 down to 0.
// - Call fills program counter bits 12 and 11 from latch bits 4 and 3.
// - Call takes two cycles and leaves every status flag unchanged.
// - Branch loads its 11-bit literal into the counter, takes two cycles, no stack or flags.
// - Watchdog-clear zeroes the watchdog counter and its prescaler in one cycle.
// - Watchdog-clear sets both the timeout flag and the powerdown flag to one.
// - Or-literal ORs the accumulator with the literal into the accumulator and updates zero.
`timescale 1ns/1ps

module mie_exec (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [mie_pkg::PC_W-1:0] pc_out,
  output logic [mie_pkg::PC_W-1:0] stack_push_data,
  output logic stack_push,
  output logic watchdog_clear,
  output logic prescaler_clear
);
  import mie_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    mie_state_type state;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] file_in;
    logic [DATA_W-1:0] file_out;
    logic [FADDR_W-1:0] file_addr;
    logic file_valid;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] latch;
    logic zero_flag;
    logic powerdown_flag;
    logic timeout_flag;
    logic [PC_W-1:0] stack_top_entry;
    logic push;
    logic [DATA_W-1:0] watchdog_counter;
    logic wd_clr;
    logic ps_clr;
  } mie_regs_type;

  mie_regs_type s_r;
  mie_regs_type s_nxt;

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [INSTR_W-1:0] ins;
    logic [DATA_W-1:0] res;
    logic has_res;
    logic upd_zero;
    logic skip_op;
    logic [PC_W-1:0] target;
    ins = hwdata[INSTR_W-1:0];
    res = ZERO_BYTE;
    has_res = 1'b0;
    upd_zero = 1'b1;
    skip_op = 1'b0;
    target = {s_r.latch[LATCH_HI:LATCH_LO], ins[10:0]};
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    s_nxt.wd_clr = 1'b0;
    s_nxt.ps_clr = 1'b0;
    // The second cycle of a two-cycle instruction executes nothing.
    if (s_r.state == MIE_ST_NOP) begin
      s_nxt.state = MIE_ST_EXEC;
    end
    if (s_r.ph_valid && s_r.ph_write) begin
      case (s_r.ph_addr)
        ADDR_INSTR: begin
          // An instruction written during the filler cycle is dropped, as fetch would discard it.
          if (s_r.state == MIE_ST_EXEC) begin
            s_nxt.pc = s_r.pc + PC_W'(ONE_BYTE);
            s_nxt.file_valid = 1'b0;
            case (ins[13:8])
              OP6_CLEAR: begin
                res = ZERO_BYTE;
                has_res = 1'b1;
              end
              OP6_DEC: begin
                res = s_r.file_in - ONE_BYTE;
                has_res = 1'b1;
              end
              OP6_INC: begin
                res = s_r.file_in + ONE_BYTE;
                has_res = 1'b1;
              end
              OP6_DECSKIP: begin
                res = s_r.file_in - ONE_BYTE;
                has_res = 1'b1;
                upd_zero = 1'b0;
                skip_op = 1'b1;
              end
              OP6_INCSKIP: begin
                res = s_r.file_in + ONE_BYTE;
                has_res = 1'b1;
                upd_zero = 1'b0;
                skip_op = 1'b1;
              end
              OP6_MOVE: begin
                res = s_r.file_in;
                has_res = 1'b1;
              end
              OP6_COM: begin
                res = ~s_r.file_in;
                has_res = 1'b1;
              end
              OP6_IOR: begin
                res = s_r.file_in | s_r.acc;
                has_res = 1'b1;
              end
              OP6_ORLIT: begin
                s_nxt.acc = s_r.acc | ins[7:0];
                s_nxt.zero_flag = ((s_r.acc | ins[7:0]) == ZERO_BYTE);
              end
              default: begin
                if (ins == OP_WDOG_CLEAR) begin
                  s_nxt.watchdog_counter = WDOG_RESET;
                  s_nxt.wd_clr = 1'b1;
                  s_nxt.ps_clr = 1'b1;
                  s_nxt.timeout_flag = 1'b1;
                  s_nxt.powerdown_flag = 1'b1;
                end else if (ins[13:10] == OP4_LOADLIT) begin
                  s_nxt.acc = ins[7:0];
                end else if (ins[13:11] == OP3_CALL) begin
                  s_nxt.stack_top_entry = s_r.pc + PC_W'(ONE_BYTE);
                  s_nxt.push = 1'b1;
                  s_nxt.pc = target;
                  s_nxt.state = MIE_ST_NOP;
                end else if (ins[13:11] == OP3_BRANCH) begin
                  s_nxt.pc = target;
                  s_nxt.state = MIE_ST_NOP;
                end
              end
            endcase
            if (has_res) begin
              // Clear-file has d=1, clear-accumulator d=0, so one path serves both.
              if (ins[DEST_BIT]) begin
                s_nxt.file_out = res;
                s_nxt.file_addr = ins[FADDR_W-1:0];
                s_nxt.file_valid = 1'b1;
              end else begin
                s_nxt.acc = res;
              end
              if (upd_zero) begin
                s_nxt.zero_flag = (res == ZERO_BYTE);
              end
              if (skip_op && res == ZERO_BYTE) begin
                s_nxt.state = MIE_ST_NOP;
              end
            end
          end
        end
        ADDR_FILE_IN: s_nxt.file_in = hwdata[DATA_W-1:0];
        ADDR_ACC: s_nxt.acc = hwdata[DATA_W-1:0];
        ADDR_PC: s_nxt.pc = hwdata[PC_W-1:0];
        ADDR_LATCH: s_nxt.latch = hwdata[DATA_W-1:0];
        ADDR_STATUS: begin
          s_nxt.zero_flag = hwdata[ST_Z];
          s_nxt.powerdown_flag = hwdata[ST_POWERDOWN];
          s_nxt.timeout_flag = hwdata[ST_TIMEOUT];
        end
        ADDR_WDOG: s_nxt.watchdog_counter = hwdata[DATA_W-1:0];
        default: begin
        end
      endcase
    end
    s_nxt.rdata = WORD_ZERO;
    if (hsel && htrans[1] && hready) begin
      s_nxt.ph_valid = 1'b1;
      s_nxt.ph_write = hwrite;
      s_nxt.ph_addr = haddr[7:0];
      if (!hwrite) begin
        // Reading the next state lets a read right behind a write see the written value.
        case (haddr[7:0])
          ADDR_FILE_IN: s_nxt.rdata = {24'h000000, s_nxt.file_in};
          ADDR_ACC: s_nxt.rdata = {24'h000000, s_nxt.acc};
          ADDR_PC: s_nxt.rdata = {19'h00000, s_nxt.pc};
          ADDR_LATCH: s_nxt.rdata = {24'h000000, s_nxt.latch};
          ADDR_STATUS: s_nxt.rdata = {28'h0000000, s_nxt.state == MIE_ST_NOP,
            s_nxt.timeout_flag, s_nxt.powerdown_flag, s_nxt.zero_flag};
          ADDR_FILE_OUT: s_nxt.rdata = {16'h0000, s_nxt.file_addr, s_nxt.file_valid,
            s_nxt.file_out};
          ADDR_STACK: s_nxt.rdata = {19'h00000, s_nxt.stack_top_entry};
          ADDR_WDOG: s_nxt.rdata = {24'h000000, s_nxt.watchdog_counter};
          default: s_nxt.rdata = WORD_ZERO;
        endcase
      end
    end else if (hready) begin
      s_nxt.ph_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.state <= MIE_ST_EXEC;
      s_r.pc <= PC_RESET;
      s_r.timeout_flag <= 1'b1;
      s_r.powerdown_flag <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Read data is registered at the address phase, so the slave never waits.
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pc_out = s_r.pc;
  assign stack_push_data = s_r.stack_top_entry;
  assign stack_push = s_r.push;
  assign watchdog_clear = s_r.wd_clr;
  assign prescaler_clear = s_r.ps_clr;

endmodule

// file: sim/mie_exec_checker.sv
// Concurrent checks on the execute block, seen only through its top ports.
// Assumes one bus master that leaves an idle cycle after every instruction write.
`timescale 1ns/1ps
module mie_exec_checker
  import mie_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [mie_pkg::PC_W-1:0] pc_out,
  input wire logic [mie_pkg::PC_W-1:0] stack_push_data,
  input wire logic stack_push,
  input wire logic watchdog_clear,
  input wire logic prescaler_clear
);
  // ----
  // Data phase tracking
  // ----
  logic wr_r, call_r, wd_r;
  logic [7:0] adr_r;
  logic [1:0] lat_r;
  logic [10:0] k_r;
  wire logic ex = wr_r && adr_r == ADDR_INSTR;
  // The latch copy follows bus writes, since its register is not a port.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      call_r <= 1'b0;
      wd_r <= 1'b0;
      adr_r <= 8'h00;
      lat_r <= 2'b00;
      k_r <= 11'h000;
    end else begin
      wr_r <= hsel & htrans[1] & hready & hwrite;
      adr_r <= haddr[7:0];
      call_r <= ex && hwdata[13:11] == OP3_CALL;
      wd_r <= ex && hwdata[13:0] == OP_WDOG_CLEAR;
      k_r <= hwdata[10:0];
      if (wr_r && adr_r == ADDR_LATCH)
        lat_r <= hwdata[4:3];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence call_s; ex && hwdata[13:11] == OP3_CALL; endsequence
  sequence jump_s; ex && hwdata[13:11] == OP3_BRANCH; endsequence
  call_push_a: assert property (
    call_s |=> stack_push_data == $past(pc_out) + 13'h1) else $error("bad return address");
  call_load_a: assert property (
    call_s |=> pc_out == {lat_r, k_r}) else $error("bad call target");
  push_only_a: assert property (
    stack_push == call_r) else $error("push not tied to call");
  jump_load_a: assert property (
    jump_s |=> pc_out == {lat_r, k_r}) else $error("bad branch target");
  pc_step_a: assert property (
    ex && hwdata[13:12] != 2'b10 |=> pc_out == $past(pc_out) + 13'h1) else $error("pc step");
  wdog_pulse_a: assert property (
    watchdog_clear == wd_r) else $error("watchdog clear pulse wrong");
  prescaler_pair_a: assert property (
    prescaler_clear == watchdog_clear) else $error("prescaler clear apart");
  bus_okay_a: assert property (
    hreadyout && !hresp) else $error("bus wait or error");
endmodule

bind mie_exec mie_exec_checker u_chk(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .pc_out, .stack_push_data, .stack_push,
  .watchdog_clear, .prescaler_clear);

// file: sim/mcu_instruction_execute_test.sv
// Self-checking bench for the execute block, driven as an AHB-Lite master.
// Assumes zero wait states; every transfer still waits on hready.
`timescale 1ns/1ps
module mcu_instruction_execute_test;
  import mie_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, stack_push, watchdog_clear, prescaler_clear;
  logic [PC_W-1:0] pc_out, stack_push_data;
  int errors = 0;
  int comparisons = 0;
  mie_exec u_dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pc_out, .stack_push_data,
    .stack_push, .watchdog_clear, .prescaler_clear);
  initial forever #20 hclk = ~hclk;
  // ----
  // Bus and check tasks
  // ----
  // Ready and read data are taken as they stand just before the rising edge.
  // Sampling them in the edge's own time step would race the registers that update them.
  task automatic wait_ready();
    logic rdy;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask
  // Returning after the data phase leaves one idle cycle before the next address.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e, input string n);
    xfer(a, 1'b0, 32'h0);
    check(n, q & m, e);
  endtask
  task automatic t(input logic [7:0] f, w, input logic [31:0] ins, input logic [7:0] ra,
      input logic [31:0] m, e, input logic z);
    wr(ADDR_FILE_IN, {24'h0, f});
    wr(ADDR_ACC, {24'h0, w});
    wr(ADDR_INSTR, ins);
    rc(ra, m, e, "result");
    rc(ADDR_STATUS, 32'h1, {31'h0, z}, "zero");
  endtask
  function automatic logic [31:0] fop(input logic [5:0] o, input logic d);
    return {18'h0, o, d, 7'h25};
  endfunction
  function automatic logic [31:0] fo(input logic [7:0] r);
    return {16'h0, 7'h25, 1'b1, r};
  endfunction
  task automatic conclude();
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rc(ADDR_STATUS, 32'hF, 32'h6, "status");
    rc(ADDR_PC, 32'h1FFF, 32'h0, "pc");
    rc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    t(8'hFF, 8'h00, fop(OP6_INC, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h00), 1'b1);
    t(8'h05, 8'h00, fop(OP6_DEC, 1'b0), ADDR_ACC, 32'hFF, 32'h04, 1'b0);
    rc(ADDR_FILE_OUT, 32'h100, 32'h0, "file valid");
    t(8'h01, 8'h00, fop(OP6_DEC, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h00), 1'b1);
    t(8'h80, 8'h00, fop(OP6_MOVE, 1'b0), ADDR_ACC, 32'hFF, 32'h80, 1'b0);
    t(8'h00, 8'h55, fop(OP6_MOVE, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h00), 1'b1);
    t(8'h13, 8'h00, fop(OP6_COM, 1'b0), ADDR_ACC, 32'hFF, 32'hEC, 1'b0);
    t(8'h12, 8'h34, fop(OP6_CLEAR, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h00), 1'b1);
    t(8'h13, 8'h91, fop(OP6_IOR, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h93), 1'b0);
    t(8'h00, 8'h5A, {18'h0, OP6_CLEAR, 8'h03}, ADDR_ACC, 32'hFF, 32'h00, 1'b1);
    t(8'h00, 8'h9A, {18'h0, OP6_ORLIT, 8'h35}, ADDR_ACC, 32'hFF, 32'hBF, 1'b0);
    t(8'h00, 8'h77, {18'h0, OP4_LOADLIT, 10'h000}, ADDR_ACC, 32'hFF, 32'h00, 1'b0);
    t(8'h00, 8'h00, {18'h0, OP6_ORLIT, 8'h00}, ADDR_ACC, 32'hFF, 32'h00, 1'b1);
    t(8'hFF, 8'h11, fop(OP6_INCSKIP, 1'b0), ADDR_ACC, 32'hFF, 32'h00, 1'b1);
    t(8'h05, 8'h11, fop(OP6_DECSKIP, 1'b1), ADDR_FILE_OUT, 32'hFFFF, fo(8'h04), 1'b1);
    wr(ADDR_LATCH, 32'h18);
    wr(ADDR_PC, 32'h0123);
    wr(ADDR_INSTR, {18'h0, OP3_CALL, 11'h7FF});
    rc(ADDR_PC, 32'h1FFF, 32'h1FFF, "pc");
    rc(ADDR_STACK, 32'h1FFF, 32'h0124, "stack");
    rc(ADDR_STATUS, 32'h7, 32'h7, "status");
    wr(ADDR_LATCH, 32'h08);
    wr(ADDR_INSTR, {18'h0, OP3_BRANCH, 11'h000});
    rc(ADDR_PC, 32'h1FFF, 32'h0800, "pc");
    rc(ADDR_STACK, 32'h1FFF, 32'h0124, "stack");
    wr(ADDR_WDOG, 32'h5A);
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_INSTR, {18'h0, OP_WDOG_CLEAR});
    rc(ADDR_WDOG, 32'hFF, 32'h0, "watchdog");
    rc(ADDR_STATUS, 32'h6, 32'h6, "status");
    conclude();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    conclude();
  end
endmodule
